//--- tmr_pkg.sv
/*
  Package for the 8-bit timer/counter: register indices, field positions,
  reset values, clock-select and waveform-mode codes.
  Assumes a plain register port with 8-bit data and one-cycle strobes.
*/
package tmr_pkg;
  localparam logic [2:0] TMR_ADDR_CTRL = 3'h0;
  localparam logic [2:0] TMR_ADDR_COUNT = 3'h1;
  localparam logic [2:0] TMR_ADDR_COMPARE = 3'h2;
  localparam logic [2:0] TMR_ADDR_MASK = 3'h3;
  localparam logic [2:0] TMR_ADDR_FLAG = 3'h4;
  localparam logic [2:0] TMR_ADDR_FORCE = 3'h5;

  // control register fields
  localparam int TMR_CS_LSB = 0;
  localparam int TMR_WGM_LSB = 3;
  localparam int TMR_COM_LSB = 5;
  // flag, mask and force bit positions
  localparam int TMR_BIT_OVF = 0;
  localparam int TMR_BIT_CMP = 1;
  localparam int TMR_BIT_FORCE = 0;

  localparam logic [7:0] TMR_BOTTOM = 8'h00;
  localparam logic [7:0] TMR_MAX = 8'hff;
  localparam logic [7:0] TMR_ZERO8 = 8'h00;

  localparam logic [2:0] TMR_CS_STOP = 3'h0;
  localparam logic [2:0] TMR_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMR_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMR_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMR_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR_CS_EXT_RISE = 3'h7;

  localparam logic [1:0] TMR_WGM_NORMAL = 2'h0;
  localparam logic [1:0] TMR_WGM_PCPWM = 2'h1;
  localparam logic [1:0] TMR_WGM_CTC = 2'h2;
  localparam logic [1:0] TMR_WGM_FAST = 2'h3;

  localparam logic [1:0] TMR_COM_NONE = 2'h0;
  localparam logic [1:0] TMR_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR_COM_CLEAR = 2'h2;
  localparam logic [1:0] TMR_COM_SET = 2'h3;

  localparam int TMR_PRESCALE_W = 10;
endpackage : tmr_pkg

//--- tmr_tick_sel.sv
/*
  Timer tick selection: free-running prescaler plus external pin edge
  detector, producing a one-cycle tick per selected event.
  Assumes the external pin is already synchronous to clk.
*/
module tmr_tick_sel
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] clock_select_field,
  input wire logic external_count_pin,
  output logic timer_tick
);
  typedef struct packed {
    logic [TMR_PRESCALE_W-1:0] pre;
    logic pin_d;
  } tmr_tick_state_type;

  tmr_tick_state_type st_r;
  tmr_tick_state_type st_nxt;
  logic [TMR_PRESCALE_W-1:0] pre_inc;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pre = st_r.pre + 10'h001;
    st_nxt.pin_d = external_count_pin;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // tap pulses fire when the low bits of the prescaler wrap
  assign pre_inc = st_r.pre + 10'h001;

  always_comb begin
    case (clock_select_field)
      TMR_CS_STOP: timer_tick = 1'b0;
      TMR_CS_DIV1: timer_tick = 1'b1;
      TMR_CS_DIV8: timer_tick = (pre_inc[2:0] == 3'h0);
      TMR_CS_DIV64: timer_tick = (pre_inc[5:0] == 6'h00);
      TMR_CS_DIV256: timer_tick = (pre_inc[7:0] == 8'h00);
      TMR_CS_DIV1024: timer_tick = (pre_inc == 10'h000);
      TMR_CS_EXT_FALL: timer_tick = st_r.pin_d & ~external_count_pin;
      TMR_CS_EXT_RISE: timer_tick = ~st_r.pin_d & external_count_pin;
      default: timer_tick = 1'b0;
    endcase
  end

  property p_stop_no_tick;
    @(posedge clk) disable iff (reset)
      (clock_select_field == TMR_CS_STOP) |-> !timer_tick;
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick)
    else $error("tick produced while clock select is stopped");
endmodule : tmr_tick_sel

//--- tmr_timer8.sv
/*
  8-bit timer/counter with one compare channel and waveform output.
  Assumes a single-cycle register port, synchronous inputs, and a CPU
  that reports interrupt service through the ack inputs.
*/
// Operation
// - count and compare values are 8-bit CPU-accessible registers.
// - tick comes from prescaler or external pin per clock select.
// - clock select zero gives no tick; counter holds.
// - counter read/write anytime; CPU write beats clear or count.
// - bottom flagged at 0x00, max at 0xff, both used by waveform.
// - top is 0xff or the compare value depending on mode.
// - each tick clears, increments or decrements per mode.
// - overflow flag set where the mode says; may request interrupt.
// - compare runs always; equality sets compare flag one tick later.
// - compare interrupt needs enable bit and global enable.
// - compare flag clears on service or writing one.
// - all sources in flag register, each masked in mask register.
// - compare value double buffered only in PWM modes.
// - buffer copied to active compare only at top or bottom.
// - output driven from match, max, bottom per mode and output mode.
// - force strobe in non-PWM modes makes a forced match.
// - forced match sets no flag, no clear; updates output like match.
// - counter write blocks compare match in the next tick.
// - compare output register keeps value across mode changes.
// - output mode field is unbuffered and acts at once.
// - normal mode counts up, wraps, overflow as count becomes zero.
// - clear-on-compare mode clears counter at match; compare is top.
// - fast PWM counts bottom to max; output per inverting choice.
// - output mode zero leaves the output register alone.
module tmr_timer8
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic overflow_irq_ack,
  input wire logic compare_irq_ack,
  output logic overflow_irq,
  output logic compare_irq,
  output logic compare_output,
  output logic compare_output_override
);
  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [2:0] clock_select_field;
    logic [1:0] waveform_mode_field;
    logic [1:0] compare_output_mode_field;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic overflow_flag;
    logic compare_flag;
    logic count_down;
    logic block_match;
    logic match_pend;
    logic oc;
    logic [7:0] rdata;
    logic ovf_irq;
    logic cmp_irq;
    logic oc_en;
  } tmr_state_type;

  tmr_state_type st_r;
  tmr_state_type st_nxt;
  logic timer_tick;
  logic pwm_mode;
  logic match;
  logic at_max;
  logic at_bottom;
  logic [7:0] top_value;
  logic wr_count;
  logic wr_compare;
  logic wr_flag;
  logic force_match;
  logic [7:0] cnt_next;
  logic wrap_ovf;
  logic load_buf;

  tmr_tick_sel u_tick (
    .clk(clk),
    .reset(reset),
    .clock_select_field(st_r.clock_select_field),
    .external_count_pin(external_count_pin),
    .timer_tick(timer_tick)
  );

  assign pwm_mode = st_r.waveform_mode_field[0];
  assign match = (st_r.count_value == st_r.compare_value);
  assign at_max = (st_r.count_value == TMR_MAX);
  assign at_bottom = (st_r.count_value == TMR_BOTTOM);
  assign top_value = (st_r.waveform_mode_field == TMR_WGM_CTC) ?
                     st_r.compare_value : TMR_MAX;
  assign wr_count = reg_write && (reg_addr == TMR_ADDR_COUNT);
  assign wr_compare = reg_write && (reg_addr == TMR_ADDR_COMPARE);
  assign wr_flag = reg_write && (reg_addr == TMR_ADDR_FLAG);
  assign force_match = reg_write && (reg_addr == TMR_ADDR_FORCE) &&
                       reg_wdata[TMR_BIT_FORCE] && !pwm_mode;

  // counter sequence and overflow point per waveform mode
  always_comb begin
    cnt_next = st_r.count_value;
    wrap_ovf = 1'b0;
    load_buf = 1'b0;
    case (st_r.waveform_mode_field)
      TMR_WGM_NORMAL: begin
        cnt_next = st_r.count_value + 8'h01;
        wrap_ovf = at_max;
      end
      TMR_WGM_CTC: begin
        if (st_r.count_value == top_value) begin
          cnt_next = TMR_BOTTOM;
        end else begin
          cnt_next = st_r.count_value + 8'h01;
        end
        wrap_ovf = at_max;
      end
      TMR_WGM_FAST: begin
        cnt_next = st_r.count_value + 8'h01;
        wrap_ovf = at_max;
        load_buf = at_max;
      end
      TMR_WGM_PCPWM: begin
        // turn round at both ends; bottom must not wrap to max
        if (at_max) begin
          cnt_next = st_r.count_value - 8'h01;
          load_buf = 1'b1;
        end else if (at_bottom || !st_r.count_down) begin
          cnt_next = st_r.count_value + 8'h01;
        end else begin
          cnt_next = st_r.count_value - 8'h01;
        end
        wrap_ovf = at_bottom && st_r.count_down;
      end
      default: begin
        cnt_next = st_r.count_value;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf_irq = 1'b0;
    st_nxt.cmp_irq = 1'b0;
    if (timer_tick) begin
      st_nxt.count_value = cnt_next;
      st_nxt.block_match = 1'b0;
      st_nxt.match_pend = match && !st_r.block_match;
      if (st_r.waveform_mode_field == TMR_WGM_PCPWM) begin
        if (at_max) begin
          st_nxt.count_down = 1'b1;
        end else if (at_bottom) begin
          st_nxt.count_down = 1'b0;
        end
      end else begin
        st_nxt.count_down = 1'b0;
      end
      if (load_buf) begin
        st_nxt.compare_value = st_r.compare_buffer;
      end
      // waveform generator; mode field none leaves oc alone
      if (match && !st_r.block_match) begin
        case (st_r.compare_output_mode_field)
          TMR_COM_TOGGLE: begin
            if (!pwm_mode) begin
              st_nxt.oc = ~st_r.oc;
            end
          end
          TMR_COM_CLEAR: begin
            st_nxt.oc = (st_r.waveform_mode_field == TMR_WGM_PCPWM) ?
                        st_r.count_down : 1'b0;
          end
          TMR_COM_SET: begin
            st_nxt.oc = (st_r.waveform_mode_field == TMR_WGM_PCPWM) ?
                        !st_r.count_down : 1'b1;
          end
          default: begin
            st_nxt.oc = st_r.oc;
          end
        endcase
      end
      if (st_r.waveform_mode_field == TMR_WGM_FAST && at_max &&
          st_r.compare_value != TMR_MAX) begin
        if (st_r.compare_output_mode_field == TMR_COM_CLEAR) begin
          st_nxt.oc = 1'b1;
        end else if (st_r.compare_output_mode_field == TMR_COM_SET) begin
          st_nxt.oc = 1'b0;
        end
      end
    end
    // flag set one tick after the match
    if (timer_tick && st_r.match_pend) begin
      st_nxt.compare_flag = 1'b1;
    end else if (compare_irq_ack || (wr_flag && reg_wdata[TMR_BIT_CMP])) begin
      st_nxt.compare_flag = 1'b0;
    end
    if (timer_tick && wrap_ovf) begin
      st_nxt.overflow_flag = 1'b1;
    end else if (overflow_irq_ack ||
                 (wr_flag && reg_wdata[TMR_BIT_OVF])) begin
      st_nxt.overflow_flag = 1'b0;
    end
    if (force_match) begin
      case (st_r.compare_output_mode_field)
        TMR_COM_TOGGLE: st_nxt.oc = ~st_r.oc;
        TMR_COM_CLEAR: st_nxt.oc = 1'b0;
        TMR_COM_SET: st_nxt.oc = 1'b1;
        default: st_nxt.oc = st_r.oc;
      endcase
    end
    if (reg_write) begin
      case (reg_addr)
        TMR_ADDR_CTRL: begin
          st_nxt.clock_select_field = reg_wdata[TMR_CS_LSB +: 3];
          st_nxt.waveform_mode_field = reg_wdata[TMR_WGM_LSB +: 2];
          st_nxt.compare_output_mode_field = reg_wdata[TMR_COM_LSB +: 2];
        end
        TMR_ADDR_COUNT: begin
          st_nxt.count_value = reg_wdata;
          st_nxt.block_match = 1'b1;
          st_nxt.match_pend = 1'b0;
        end
        TMR_ADDR_COMPARE: begin
          st_nxt.compare_buffer = reg_wdata;
          if (!pwm_mode) begin
            st_nxt.compare_value = reg_wdata;
          end
        end
        TMR_ADDR_MASK: begin
          st_nxt.overflow_irq_enable = reg_wdata[TMR_BIT_OVF];
          st_nxt.compare_irq_enable = reg_wdata[TMR_BIT_CMP];
        end
        default: begin
          st_nxt.rdata = st_nxt.rdata;
        end
      endcase
    end
    st_nxt.rdata = TMR_ZERO8;
    if (reg_read) begin
      case (reg_addr)
        TMR_ADDR_CTRL: st_nxt.rdata = {1'b0, st_r.compare_output_mode_field,
          st_r.waveform_mode_field, st_r.clock_select_field};
        TMR_ADDR_COUNT: st_nxt.rdata = st_r.count_value;
        TMR_ADDR_COMPARE: st_nxt.rdata = pwm_mode ? st_r.compare_buffer :
                                         st_r.compare_value;
        TMR_ADDR_MASK: st_nxt.rdata = {6'h00, st_r.compare_irq_enable,
                                       st_r.overflow_irq_enable};
        TMR_ADDR_FLAG: st_nxt.rdata = {6'h00, st_r.compare_flag,
                                       st_r.overflow_flag};
        default: st_nxt.rdata = TMR_ZERO8;
      endcase
    end
    st_nxt.ovf_irq = st_nxt.overflow_flag && st_nxt.overflow_irq_enable &&
                     global_irq_enable;
    st_nxt.cmp_irq = st_nxt.compare_flag && st_nxt.compare_irq_enable &&
                     global_irq_enable;
    st_nxt.oc_en = (st_nxt.compare_output_mode_field !=
                    TMR_COM_NONE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign overflow_irq = st_r.ovf_irq;
  assign compare_irq = st_r.cmp_irq;
  assign compare_output = st_r.oc;
  assign compare_output_override = st_r.oc_en;

  property p_cmp_flag_after_match;
    @(posedge clk) disable iff (reset)
      (timer_tick && st_r.match_pend) |=> st_r.compare_flag;
  endproperty
  a_cmp_flag_after_match: assert property (p_cmp_flag_after_match)
    else $error("compare flag not set one tick after match");

  property p_stop_holds;
    @(posedge clk) disable iff (reset)
      (st_r.clock_select_field == TMR_CS_STOP && !reg_write) |=>
      $stable(st_r.count_value);
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("counter moved while stopped");

  property p_write_wins;
    @(posedge clk) disable iff (reset)
      wr_count |=> st_r.count_value == $past(reg_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("counter write lost");

  property p_normal_ovf;
    @(posedge clk) disable iff (reset)
      (timer_tick && st_r.waveform_mode_field == TMR_WGM_NORMAL && at_max
       && !reg_write) |=> st_r.overflow_flag && st_r.count_value == 8'h00;
  endproperty
  a_normal_ovf: assert property (p_normal_ovf)
    else $error("normal mode wrap did not set overflow");

  property p_ctc_clear;
    @(posedge clk) disable iff (reset)
      (timer_tick && st_r.waveform_mode_field == TMR_WGM_CTC && match &&
       !reg_write) |=> st_r.count_value == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("clear-on-compare did not clear");

  property p_force_no_flag;
    @(posedge clk) disable iff (reset)
      (force_match && !timer_tick && !st_r.compare_flag) |=>
      !st_r.compare_flag;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced match set the compare flag");

  property p_block_after_write;
    @(posedge clk) disable iff (reset)
      wr_count |=> !st_r.match_pend;
  endproperty
  a_block_after_write: assert property (p_block_after_write)
    else $error("match pending right after counter write");

  property p_cmp_irq_gate;
    @(posedge clk) disable iff (reset)
      compare_irq |-> $past(global_irq_enable) && st_r.compare_irq_enable;
  endproperty
  a_cmp_irq_gate: assert property (p_cmp_irq_gate)
    else $error("compare interrupt without enables");

  property p_com_none_hold;
    @(posedge clk) disable iff (reset)
      (st_r.compare_output_mode_field == TMR_COM_NONE && !reg_write) |=>
      $stable(st_r.oc);
  endproperty
  a_com_none_hold: assert property (p_com_none_hold)
    else $error("output changed with output mode none");
endmodule : tmr_timer8

//--- tmr_timer8_tb.sv
/*
  Self-checking bench for the 8-bit timer/counter tmr_timer8.
  Assumes tmr_pkg is compiled first; the bench drives all ports itself.
*/
module tmr_timer8_tb
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic clk, reset, reg_write, reg_read, external_count_pin;
  logic global_irq_enable, overflow_irq_ack, compare_irq_ack;
  logic overflow_irq, compare_irq, compare_output, compare_output_override;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, c0;
  logic prev_out;
  int errors, checked, cycles, toggles, n;
  logic [1:0] com_tab [4];
  logic exp_tab [4];

  tmr_timer8 DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .external_count_pin(external_count_pin),
    .global_irq_enable(global_irq_enable),
    .overflow_irq_ack(overflow_irq_ack), .compare_irq_ack(compare_irq_ack),
    .overflow_irq(overflow_irq), .compare_irq(compare_irq),
    .compare_output(compare_output),
    .compare_output_override(compare_output_override));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (compare_output !== prev_out) toggles = toggles + 1;
    prev_out = compare_output;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic check_range(input logic [15:0] seen, input int lo,
                             input int hi);
    check({7'h00, (seen >= lo && seen <= hi)}, 8'h01);
  endtask : check_range

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic ctrl(input logic [2:0] cs, input logic [1:0] wgm,
                      input logic [1:0] com);
    wr(TMR_ADDR_CTRL, {1'b0, com, wgm, cs});
  endtask : ctrl

  // poll one flag bit with a bounded number of reads
  task automatic poll_flag(input int b, input int lim);
    int k;
    k = 0;
    rd(TMR_ADDR_FLAG, v);
    while (v[b] !== 1'b1 && k < lim) begin
      rd(TMR_ADDR_FLAG, v);
      k++;
    end
  endtask : poll_flag

  task automatic pulse_pin(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk) external_count_pin <= 1'b1;
      repeat (4) @(posedge clk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulse_pin

  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    external_count_pin = 1'b0;
    global_irq_enable = 1'b0;
    overflow_irq_ack = 1'b0;
    compare_irq_ack = 1'b0;
    errors = 0;
    checked = 0;
    cycles = 0;
    toggles = 0;
    prev_out = 1'b0;
    com_tab = '{TMR_COM_SET, TMR_COM_CLEAR, TMR_COM_TOGGLE, TMR_COM_NONE};
    exp_tab = '{1'b1, 1'b0, 1'b1, 1'b1};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(3'(i), v);
      check(v, TMR_ZERO8);
    end
    check({7'h00, compare_output}, 8'h00);
    $display("test reset values done");

    wr(TMR_ADDR_COUNT, 8'h5a);
    wr(TMR_ADDR_COMPARE, 8'ha5);
    rd(TMR_ADDR_COUNT, v);
    check(v, 8'h5a);
    rd(TMR_ADDR_COMPARE, v);
    check(v, 8'ha5);
    repeat (20) @(posedge clk);
    rd(TMR_ADDR_COUNT, v);
    check(v, 8'h5a);
    wr(3'h6, 8'hff);
    rd(3'h6, v);
    check(v, TMR_ZERO8);
    $display("test register access done");

    wr(TMR_ADDR_MASK, 8'h03);
    wr(TMR_ADDR_COUNT, 8'hfd);
    ctrl(TMR_CS_DIV1, TMR_WGM_NORMAL, TMR_COM_NONE);
    poll_flag(TMR_BIT_OVF, 20);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    check({7'h00, v[TMR_BIT_OVF]}, 8'h01);
    rd(TMR_ADDR_COUNT, v);
    check_range(v, 0, 32);
    @(posedge clk) global_irq_enable <= 1'b1;
    repeat (3) @(posedge clk);
    check({7'h00, overflow_irq}, 8'h01);
    wr(TMR_ADDR_FLAG, 8'h01);
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_OVF]}, 8'h00);
    $display("test overflow done");

    wr(TMR_ADDR_COMPARE, 8'h08);
    wr(TMR_ADDR_COUNT, 8'h00);
    ctrl(TMR_CS_DIV1, TMR_WGM_NORMAL, TMR_COM_NONE);
    poll_flag(TMR_BIT_CMP, 20);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    check({7'h00, v[TMR_BIT_CMP]}, 8'h01);
    repeat (3) @(posedge clk);
    check({7'h00, compare_irq}, 8'h01);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h00, compare_irq}, 8'h00);
    compare_irq_ack <= 1'b1;
    @(posedge clk) compare_irq_ack <= 1'b0;
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_CMP]}, 8'h00);
    $display("test compare flag done");

    wr(TMR_ADDR_COMPARE, 8'h20);
    wr(TMR_ADDR_COUNT, 8'h20);
    ctrl(TMR_CS_DIV1, TMR_WGM_NORMAL, TMR_COM_NONE);
    repeat (10) @(posedge clk);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_CMP]}, 8'h00);
    $display("test match blocking done");

    rd(TMR_ADDR_COUNT, c0);
    for (int i = 0; i < 4; i++) begin
      ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, com_tab[i]);
      #1 check({7'h00, compare_output_override},
               {7'h00, com_tab[i] != 2'h0});
      wr(TMR_ADDR_FORCE, 8'h01);
      repeat (2) @(posedge clk);
      check({7'h00, compare_output}, {7'h00, exp_tab[i]});
    end
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_CMP]}, 8'h00);
    rd(TMR_ADDR_COUNT, v);
    check(v, c0);
    ctrl(TMR_CS_STOP, TMR_WGM_FAST, TMR_COM_TOGGLE);
    wr(TMR_ADDR_FORCE, 8'h01);
    repeat (2) @(posedge clk);
    check({7'h00, compare_output}, 8'h01);
    ctrl(TMR_CS_STOP, TMR_WGM_PCPWM, TMR_COM_NONE);
    check({7'h00, compare_output}, 8'h01);
    $display("test forced match done");

    ctrl(TMR_CS_STOP, TMR_WGM_CTC, TMR_COM_TOGGLE);
    wr(TMR_ADDR_COMPARE, 8'h05);
    wr(TMR_ADDR_COUNT, 8'h00);
    toggles = 0;
    ctrl(TMR_CS_DIV1, TMR_WGM_CTC, TMR_COM_TOGGLE);
    repeat (60) @(posedge clk);
    ctrl(TMR_CS_STOP, TMR_WGM_CTC, TMR_COM_TOGGLE);
    check_range(16'(toggles), 8, 11);
    rd(TMR_ADDR_COUNT, v);
    check_range(v, 0, 5);
    $display("test clear on compare done");

    wr(TMR_ADDR_COUNT, 8'hf0);
    ctrl(TMR_CS_DIV1, TMR_WGM_PCPWM, TMR_COM_NONE);
    repeat (30) @(posedge clk);
    ctrl(TMR_CS_STOP, TMR_WGM_PCPWM, TMR_COM_NONE);
    rd(TMR_ADDR_COUNT, v);
    check_range(v, 8'hd8, 8'hfe);
    // still counting down: run through bottom and back up
    wr(TMR_ADDR_COUNT, 8'h03);
    ctrl(TMR_CS_DIV1, TMR_WGM_PCPWM, TMR_COM_NONE);
    repeat (6) @(posedge clk);
    ctrl(TMR_CS_STOP, TMR_WGM_PCPWM, TMR_COM_NONE);
    rd(TMR_ADDR_COUNT, v);
    check(v, 8'h05);
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_OVF]}, 8'h01);
    @(posedge clk) overflow_irq_ack <= 1'b1;
    @(posedge clk) overflow_irq_ack <= 1'b0;
    rd(TMR_ADDR_FLAG, v);
    check({7'h00, v[TMR_BIT_OVF]}, 8'h00);
    $display("test phase correct done");

    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_SET);
    wr(TMR_ADDR_COMPARE, 8'h80);
    wr(TMR_ADDR_FORCE, 8'h01);
    wr(TMR_ADDR_COUNT, 8'h00);
    ctrl(TMR_CS_DIV1, TMR_WGM_FAST, TMR_COM_CLEAR);
    repeat (64) @(posedge clk);
    wr(TMR_ADDR_COMPARE, 8'h20);
    n = 0;
    while (compare_output === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check_range(16'(n), 8'h30, 8'h60);
    n = 0;
    while (compare_output !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (compare_output === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check_range(16'(n), 8'h1e, 8'h24);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    $display("test fast pwm done");

    wr(TMR_ADDR_COUNT, 8'h00);
    ctrl(TMR_CS_EXT_RISE, TMR_WGM_NORMAL, TMR_COM_NONE);
    pulse_pin(5);
    ctrl(TMR_CS_EXT_FALL, TMR_WGM_NORMAL, TMR_COM_NONE);
    pulse_pin(3);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    rd(TMR_ADDR_COUNT, v);
    check(v, 8'h08);
    wr(TMR_ADDR_COUNT, 8'h00);
    ctrl(TMR_CS_DIV8, TMR_WGM_NORMAL, TMR_COM_NONE);
    repeat (80) @(posedge clk);
    ctrl(TMR_CS_STOP, TMR_WGM_NORMAL, TMR_COM_NONE);
    rd(TMR_ADDR_COUNT, v);
    check_range(v, 9, 11);
    $display("test clock sources done");
    stop_test();
  end
endmodule : tmr_timer8_tb
